/* pmd_pkg.sv */
// Purpose: shared constants and types of the parallel move decoder
// Assumes: 24-bit instruction words, 56-bit accumulators
// Notes: register codes of the accumulators are fixed here for all forms
package pmd_pkg;
  localparam int WORD_W = 24;
  localparam int ACC_W = 56;
  localparam logic [3:0] XR1_TOP = 4'h1;
  localparam logic [6:0] XR2_TOP = 7'h04;
  localparam logic [12:0] LDISP_TOP = 13'h016e;
  localparam logic [6:0] SDISP_TOP = 7'h01;
  localparam int BIT_DIR = 15;
  localparam int BIT_FORM = 14;
  localparam logic [5:0] EA_ABS_LONG = 6'h30;
  localparam logic [5:0] EA_IMM = 6'h34;
  localparam logic [5:0] REG_ACC_A = 6'h0e;
  localparam logic [5:0] REG_ACC_B = 6'h0f;
  localparam logic [1:0] MSEL_ACC_A = 2'h2;
  localparam logic [1:0] MSEL_ACC_B = 2'h3;
  localparam logic [23:0] SAT_POS = 24'h7fffff;
  localparam logic [23:0] SAT_NEG = 24'h800000;

  typedef enum logic [2:0] {
    FORM_NONE, FORM_XR1, FORM_XR2, FORM_YEA, FORM_YABS, FORM_YR2,
    FORM_YLDISP, FORM_YSDISP
  } pmd_form_type;

  typedef enum logic {ST_IDLE, ST_EXT} pmd_fsm_type;

  typedef struct packed {
    logic valid;
    pmd_form_type form;
    logic y_space;
    logic mem_write;
    logic [5:0] ea;
    logic [5:0] short_addr;
    logic [2:0] ptr;
    logic [23:0] disp;
    logic ext_used;
    logic [23:0] ext;
    logic [5:0] reg_code;
    logic copy_valid;
    logic copy_src_b;
    logic copy_dst_1;
    logic acc_load;
    logic acc_sel_b;
    logic store_sat;
    logic [23:0] store_data;
  } pmd_move_type;

  typedef struct packed {
    logic valid;
    logic [7:0] op;
  } pmd_alu_type;

  typedef struct packed {
    pmd_fsm_type fsm;
    logic [23:0] insn;
    pmd_move_type move;
    pmd_alu_type alu;
    logic ext_req;
    logic insn_ready;
    logic illegal;
  } pmd_state_type;
endpackage

/* pmd_decoder.sv */
// Purpose: decode and issue X-plus-register and Y memory parallel moves
// Assumes: program memory and data ALU run on sys_clk, no synchronisers
// Notes: one instruction in flight; extension word stalls the fetch side
`timescale 1ns/1ps
module pmd_decoder (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic insn_valid,
  input wire logic [23:0] insn_word,
  input wire logic ext_valid,
  input wire logic [23:0] ext_word,
  input wire logic [55:0] acc_one,
  input wire logic [55:0] acc_two,
  output pmd_pkg::pmd_move_type move,
  output pmd_pkg::pmd_alu_type alu,
  output logic insn_ready,
  output logic ext_req,
  output logic illegal
);
  import pmd_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic ea_long(input logic [5:0] ea);
    ea_long = (ea == EA_ABS_LONG) || (ea == EA_IMM);
  endfunction

  function automatic pmd_move_type decode(input logic [23:0] w);
    pmd_move_type m;
    m = '0;
    m.form = FORM_NONE;
    m.mem_write = !w[BIT_DIR];
    m.ea = w[13:8];
    // no hazard check on sources: aliasing ALU and move is legal
    if (w[23:20] == XR1_TOP && !w[BIT_FORM]) begin
      m.form = FORM_XR1;
      m.reg_code = {4'h0, w[19:18]};
      m.copy_valid = 1'b1;
      m.copy_src_b = w[17];
      m.copy_dst_1 = w[16];
    end else if (w[23:22] == 2'b01 && w[19]) begin
      m.y_space = 1'b1;
      m.reg_code = {1'b0, w[21:20], w[18:16]};
      if (w[BIT_FORM]) begin
        m.form = FORM_YEA;
      end else begin
        m.form = FORM_YABS;
        m.short_addr = w[13:8];
      end
    end else if (w[23:17] == XR2_TOP && !w[BIT_FORM]) begin
      m.form = w[BIT_DIR] ? FORM_YR2 : FORM_XR2;
      m.y_space = w[BIT_DIR];
      m.mem_write = 1'b1;
      m.acc_load = 1'b1;
      m.acc_sel_b = w[16];
      m.reg_code = w[16] ? REG_ACC_B : REG_ACC_A;
    end else if (w[23:11] == LDISP_TOP && w[7]) begin
      m.form = FORM_YLDISP;
      m.y_space = 1'b1;
      m.mem_write = !w[6];
      m.ptr = w[10:8];
      m.reg_code = w[5:0];
    end else if (w[23:17] == SDISP_TOP && w[7] && w[5]) begin
      m.form = FORM_YSDISP;
      m.y_space = 1'b1;
      m.mem_write = !w[4];
      m.ptr = w[10:8];
      m.reg_code = {2'b00, w[3:0]};
      m.disp = {{17{w[16]}}, w[16:11], w[6]};
    end
    decode = m;
  endfunction

  function automatic logic wants_ext(input pmd_move_type m);
    wants_ext = (m.form == FORM_YLDISP) ||
      ((m.form == FORM_XR1 || m.form == FORM_YEA) && ea_long(m.ea));
  endfunction

  function automatic logic is_parallel(input pmd_form_type f);
    is_parallel = (f != FORM_NONE) && (f != FORM_YLDISP) &&
      (f != FORM_YSDISP);
  endfunction

  // limiting keeps an extended accumulator from wrapping in memory
  function automatic logic [24:0] limit(input logic [55:0] a);
    if (a[55:47] == {9{a[55]}}) begin
      limit = {1'b0, a[47:24]};
    end else begin
      limit = {1'b1, a[55] ? SAT_NEG : SAT_POS};
    end
  endfunction

  function automatic pmd_move_type finish(input pmd_move_type m,
      input logic [55:0] a1, input logic [55:0] a2);
    pmd_move_type r;
    logic src_acc;
    logic src_b;
    r = m;
    src_acc = 1'b0;
    src_b = 1'b0;
    if (m.form == FORM_XR1) begin
      src_acc = m.reg_code[1:0] == MSEL_ACC_A ||
        m.reg_code[1:0] == MSEL_ACC_B;
      src_b = m.reg_code[1:0] == MSEL_ACC_B;
    end else if (m.form == FORM_XR2 || m.form == FORM_YR2) begin
      src_acc = 1'b1;
      src_b = m.acc_sel_b;
    end else begin
      src_acc = m.reg_code == REG_ACC_A || m.reg_code == REG_ACC_B;
      src_b = m.reg_code == REG_ACC_B;
    end
    {r.store_sat, r.store_data} = src_b ? limit(a2) : limit(a1);
    r.store_sat = r.store_sat && src_acc && m.mem_write;
    r.valid = 1'b1;
    finish = r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pmd_state_type s_q;
  pmd_state_type s_d;
  pmd_move_type dec;
  logic take;

  assign dec = decode(insn_word);
  assign take = insn_valid && s_q.insn_ready;

  always_comb begin
    s_d = s_q;
    s_d.move.valid = 1'b0;
    s_d.move.copy_valid = 1'b0;
    s_d.alu.valid = 1'b0;
    s_d.illegal = 1'b0;
    case (s_q.fsm)
      ST_IDLE: begin
        s_d.insn_ready = 1'b1;
        if (take && dec.form != FORM_NONE) begin
          s_d.insn = insn_word;
          if ((dec.form == FORM_XR2 || dec.form == FORM_YR2) &&
              ea_long(insn_word[13:8])) begin
            s_d.illegal = 1'b1;
          end else if (wants_ext(dec)) begin
            s_d.move = dec;
            s_d.move.valid = 1'b0;
            s_d.move.copy_valid = 1'b0;
            s_d.fsm = ST_EXT;
            s_d.ext_req = 1'b1;
            s_d.insn_ready = 1'b0;
          end else begin
            s_d.move = finish(dec, acc_one, acc_two);
            // copy strobe issues with the move, visible next cycle
            s_d.alu.valid = is_parallel(dec.form);
            s_d.alu.op = insn_word[7:0];
          end
        end
      end
      ST_EXT: begin
        s_d.insn_ready = 1'b0;
        if (ext_valid) begin
          s_d.move = finish(s_q.move, acc_one, acc_two);
          s_d.move.ext_used = 1'b1;
          s_d.move.ext = ext_word;
          s_d.move.copy_valid = s_q.move.form == FORM_XR1;
          if (s_q.move.form == FORM_YLDISP) begin
            s_d.move.disp = ext_word;
          end
          s_d.alu.valid = is_parallel(s_q.move.form);
          s_d.alu.op = s_q.insn[7:0];
          s_d.fsm = ST_IDLE;
          s_d.ext_req = 1'b0;
          s_d.insn_ready = 1'b1;
        end
      end
      default: begin
        s_d = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign move = s_q.move;
  assign alu = s_q.alu;
  assign insn_ready = s_q.insn_ready;
  assign ext_req = s_q.ext_req;
  assign illegal = s_q.illegal;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_take_xr1;
    take && insn_word[23:20] == XR1_TOP && !insn_word[14] &&
      !ea_long(insn_word[13:8]);
  endsequence

  sequence s_take_short;
    take && insn_word[23:17] == SDISP_TOP && insn_word[7] && insn_word[5];
  endsequence

  sequence s_take_cls2;
    take && insn_word[23:17] == XR2_TOP && !insn_word[14] &&
      !ea_long(insn_word[13:8]);
  endsequence

  sequence s_take_yea;
    take && insn_word[23:22] == 2'b01 && insn_word[19] && insn_word[14] &&
      !ea_long(insn_word[13:8]);
  endsequence

  sequence s_take_ldisp;
    take && insn_word[23:11] == LDISP_TOP && insn_word[7];
  endsequence

  a_xr1_copy_issue: assert property (s_take_xr1 |=> move.valid &&
      move.copy_valid && move.form == FORM_XR1 && !move.y_space)
    else $error("class I move not issued with copy");

  a_xr1_fields: assert property (s_take_xr1 |=>
      move.copy_dst_1 == $past(insn_word[16]) &&
      move.copy_src_b == $past(insn_word[17]) &&
      move.reg_code[1:0] == $past(insn_word[19:18]))
    else $error("class I fields decoded wrongly");

  a_xr1_dir: assert property (s_take_xr1 |=>
      move.mem_write == !$past(insn_word[15]))
    else $error("class I direction wrong");

  a_ext_stall: assert property (ext_req && !ext_valid |=>
      ext_req && !move.valid && !insn_ready)
    else $error("extension wait left early");

  a_ext_used: assert property (ext_req && ext_valid |=>
      move.valid && move.ext_used && move.ext == $past(ext_word) &&
      !ext_req)
    else $error("extension word not used");

  a_cls2_long: assert property (take && insn_word[23:17] == XR2_TOP &&
      !insn_word[14] && ea_long(insn_word[13:8]) |=>
      illegal && !move.valid && !ext_req)
    else $error("class II long mode accepted");

  a_sat_const: assert property (move.valid && move.store_sat |->
      move.store_data == SAT_POS || move.store_data == SAT_NEG)
    else $error("saturation constant wrong");

  a_short_disp: assert property (s_take_short |=> move.valid &&
      move.form == FORM_YSDISP && !alu.valid &&
      move.disp == {{17{$past(insn_word[16])}}, $past(insn_word[16:11]),
      $past(insn_word[6])})
    else $error("short displacement wrong");

  a_long_disp: assert property (s_q.fsm == ST_EXT && ext_valid &&
      s_q.move.form == FORM_YLDISP |=> move.disp == $past(ext_word) &&
      move.ptr == $past(s_q.insn[10:8]) && !alu.valid)
    else $error("long displacement wrong");

  a_alu_pass: assert property (s_take_xr1 |=> alu.valid &&
      alu.op == $past(insn_word[7:0]))
    else $error("alu opcode not passed");

  a_y_space: assert property (take && insn_word[23:22] == 2'b01 &&
      insn_word[19] && !insn_word[14] |=> move.valid && move.y_space &&
      move.form == FORM_YABS && move.short_addr == $past(insn_word[13:8]))
    else $error("Y short address move wrong");

  a_ext_copy: assert property (ext_req && ext_valid &&
      s_q.move.form == FORM_XR1 |=> move.copy_valid)
    else $error("class I copy lost after extension");

  a_cls2_issue: assert property (s_take_cls2 |=> move.valid &&
      move.acc_load && move.mem_write &&
      move.ea == $past(insn_word[13:8]) &&
      move.acc_sel_b == $past(insn_word[16]))
    else $error("class II move decoded wrongly");

  a_yea_issue: assert property (s_take_yea |=> move.valid &&
      move.form == FORM_YEA && move.y_space &&
      move.mem_write == !$past(insn_word[15]) &&
      move.ea == $past(insn_word[13:8]))
    else $error("Y address form move wrong");

  a_ldisp_wait: assert property (s_take_ldisp |=>
      ext_req && !insn_ready && !move.valid)
    else $error("long displacement did not wait");

  a_alu_cls2: assert property (s_take_cls2 |=> alu.valid &&
      alu.op == $past(insn_word[7:0]))
    else $error("class II alu opcode not passed");

  a_ext_ready: assert property (ext_req |-> !insn_ready)
    else $error("fetch side open while waiting");
endmodule

/* pmd_prog_mem.sv */
// Purpose: program memory model that answers extension word requests
// Assumes: answers on the falling edge after a lag the bench picks
// Notes: a released word reads inverted, so stale data never matches
`timescale 1ns/1ps
module pmd_prog_mem (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ext_req,
  input wire logic [23:0] ext_data,
  input wire logic [1:0] ext_lag,
  output logic ext_valid,
  output logic [23:0] ext_word
);
  logic [1:0] lag_q;
  // ----------------------------------------
  // one extension word per request
  // ----------------------------------------
  always @(negedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_valid <= 1'b0;
      ext_word <= 24'h000000;
      lag_q <= 2'h0;
    end else if (ext_valid && !ext_req) begin
      ext_valid <= 1'b0;
      ext_word <= ~ext_word;
    end else if (ext_req && !ext_valid) begin
      if (lag_q == ext_lag) begin
        ext_valid <= 1'b1;
        ext_word <= ext_data;
        lag_q <= 2'h0;
      end else begin
        lag_q <= lag_q + 2'h1;
      end
    end
  end
endmodule

/* tb.sv */
// Purpose: self-checking bench of the parallel move decoder
// Assumes: inputs change at the falling edge
// Notes: the alu byte never targets the move destination
`timescale 1ns/1ps
module tb;
  import pmd_pkg::*;
  logic sys_clk, arst_n, insn_valid, ext_valid;
  logic insn_ready, ext_req, illegal;
  logic [23:0] insn_word, ext_word, ext_data;
  logic [55:0] acc_one, acc_two;
  logic [1:0] ext_lag;
  pmd_move_type move;
  pmd_alu_type alu;
  int mismatches, compares;

  pmd_decoder uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .insn_valid(insn_valid), .insn_word(insn_word),
    .ext_valid(ext_valid), .ext_word(ext_word), .acc_one(acc_one),
    .acc_two(acc_two), .move(move), .alu(alu),
    .insn_ready(insn_ready), .ext_req(ext_req), .illegal(illegal));
  pmd_prog_mem prog (.sys_clk(sys_clk), .arst_n(arst_n),
    .ext_req(ext_req), .ext_data(ext_data), .ext_lag(ext_lag),
    .ext_valid(ext_valid), .ext_word(ext_word));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // returns at the falling edge just after the take
  task automatic put(input logic [23:0] w);
    @(negedge sys_clk);
    while (insn_ready !== 1'b1) @(negedge sys_clk);
    insn_valid = 1'b1;
    insn_word = w;
    @(negedge sys_clk);
    insn_valid = 1'b0;
  endtask

  task automatic wait_move();
    int n;
    n = 0;
    while (move.valid !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk("move_valid", 1'b1, move.valid);
  endtask

  // both move sources name accumulator two, stored with saturation
  task automatic t_xr1();
    acc_two = 56'h00800000000000;
    put({XR1_TOP, MSEL_ACC_B, 4'hc, 6'h18, 8'h5a});
    wait_move();
    chk("form", FORM_XR1, move.form);
    chk("mem_write", 1'b1, move.mem_write);
    chk("ea", 6'h18, move.ea);
    chk("copy", 1'b1, move.copy_valid);
    chk("copy_src", 1'b1, move.copy_src_b);
    chk("copy_dst", 1'b1, move.copy_dst_1);
    chk("store", 24'h7fffff, move.store_data);
    chk("store_sat", 1'b1, move.store_sat);
    chk("alu_op", 8'h5a, alu.op);
    chk("alu_valid", 1'b1, alu.valid);
  endtask

  // slow extension word, decoder must stall the fetch side
  task automatic t_xr1_ext();
    ext_lag = 2'h2;
    ext_data = 24'h00abcd;
    put({XR1_TOP, 2'h0, 2'h0, 2'h2, EA_ABS_LONG, 8'h11});
    chk("ext_req", 1'b1, ext_req);
    chk("ready", 1'b0, insn_ready);
    wait_move();
    chk("ext", 24'h00abcd, move.ext);
    chk("ext_used", 1'b1, move.ext_used);
    chk("copy_ext", 1'b1, move.copy_valid);
    chk("mem_write", 1'b0, move.mem_write);
  endtask

  task automatic t_xr2();
    put({XR2_TOP, 1'b1, 2'h0, 6'h05, 8'h22});
    wait_move();
    chk("form", FORM_XR2, move.form);
    chk("acc_load", 1'b1, move.acc_load);
    chk("acc_sel", 1'b1, move.acc_sel_b);
    chk("mem_write", 1'b1, move.mem_write);
    chk("alu_op", 8'h22, alu.op);
    chk("ea", 6'h05, move.ea);
    put({XR2_TOP, 1'b0, 2'h2, 6'h05, 8'h00});
    chk("valid_y2", 1'b1, move.valid);
    chk("form_y2", FORM_YR2, move.form);
    chk("y_space_y2", 1'b1, move.y_space);
    chk("acc_sel_y2", 1'b0, move.acc_sel_b);
    put({XR2_TOP, 1'b0, 2'h0, EA_IMM, 8'h00});
    chk("illegal", 1'b1, illegal);
    chk("illegal_move", 1'b0, move.valid);
  endtask

  // back to back: store acc one to Y, then short absolute load
  task automatic t_y();
    acc_one = 56'hff7fffff000000;
    @(negedge sys_clk);
    while (insn_ready !== 1'b1) @(negedge sys_clk);
    insn_valid = 1'b1;
    insn_word = {8'h5e, 2'h1, 6'h1a, 8'h33};
    @(negedge sys_clk);
    insn_word = {8'h5f, 2'h2, 6'h2b, 8'h44};
    chk("valid_a", 1'b1, move.valid);
    chk("form_a", FORM_YEA, move.form);
    chk("y_space", 1'b1, move.y_space);
    chk("reg_a", REG_ACC_A, move.reg_code);
    chk("store_a", 24'h800000, move.store_data);
    @(negedge sys_clk);
    insn_valid = 1'b0;
    chk("valid_b", 1'b1, move.valid);
    chk("form_b", FORM_YABS, move.form);
    chk("short", 6'h2b, move.short_addr);
    chk("write_b", 1'b0, move.mem_write);
    chk("alu_op", 8'h44, alu.op);
  endtask

  task automatic t_ldisp();
    ext_lag = 2'h0;
    ext_data = 24'h000123;
    put({LDISP_TOP, 3'h5, 2'h3, 6'h0f});
    wait_move();
    chk("form", FORM_YLDISP, move.form);
    chk("ptr", 3'h5, move.ptr);
    chk("disp", 24'h000123, move.disp);
    chk("reg", 6'h0f, move.reg_code);
    chk("alu_valid", 1'b0, alu.valid);
  endtask

  task automatic t_sdisp();
    put({SDISP_TOP, 6'h3d, 3'h2, 4'ha, 4'h9});
    wait_move();
    chk("form", FORM_YSDISP, move.form);
    chk("ptr", 3'h2, move.ptr);
    chk("disp", 24'hfffffa, move.disp);
    chk("mem_write", 1'b1, move.mem_write);
  endtask

  initial begin
    mismatches = 0;
    compares = 0;
    arst_n = 1'b0;
    insn_valid = 1'b0;
    insn_word = 24'h000000;
    acc_one = 56'h00000000000000;
    acc_two = 56'h00000000000000;
    ext_data = 24'h000000;
    ext_lag = 2'h0;
    repeat (20) @(negedge sys_clk);
    chk("ready_rst", 1'b0, insn_ready);
    arst_n = 1'b1;
    t_xr1();
    t_xr1_ext();
    t_xr2();
    t_y();
    t_ldisp();
    t_sdisp();
    repeat (4) @(negedge sys_clk);
    conclude();
  end

  // whole run is under two hundred cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule
